// *** verilog/psi_top.sv ***
// Two-wire slave port and register file of the pressure sensor
`timescale 1ns/100ps
`default_nettype none
`include "psi_params.svh"
module psi_top import psi_pkg::*; #(
	parameter logic [175:0] CALIB      = {11{16'h5a3c}}, // Arbitrary calibration image
	parameter logic [7:0]   CHIP_ID    = 8'ha7,          // Arbitrary identification value
	parameter int unsigned  CNT_W      = 21,
	parameter int unsigned  T_TEMP_CYC = `PSI_US2CYC(`PSI_T_TEMP_US),
	parameter int unsigned  T_P0_CYC   = `PSI_US2CYC(`PSI_T_P0_US),
	parameter int unsigned  T_P1_CYC   = `PSI_US2CYC(`PSI_T_P1_US),
	parameter int unsigned  T_P2_CYC   = `PSI_US2CYC(`PSI_T_P2_US),
	parameter int unsigned  T_P3_CYC   = `PSI_US2CYC(`PSI_T_P3_US)
) (
	input  wire logic        clk_sys_i,          // System clock, 50 MHz
	input  wire logic        rstn_i,             // Async power-on reset, active low
	input  wire logic        scl_i,              // Bus clock, clocks the link logic
	input  wire logic        sda_i,              // Bus data line level
	output logic             sda_o,              // Data drive value, always low
	output logic             sda_oe_o,           // Data pulled low while high
	output logic             scl_o,              // Clock drive value, always low
	output logic             scl_oe_o,           // Clock never stretched
	input  wire logic [15:0] raw_temperature_i,  // Front end temperature word
	input  wire logic [18:0] raw_pressure_i      // Front end pressure word
);
	psi_conv_if cif();

	// Link domain, clocked by the bus clock
	psi_link_st_t st;
	psi_link_st_t next_st;
	logic [3:0]   bit_cnt;
	logic [3:0]   next_bit_cnt;
	logic [6:0]   sh;
	logic [6:0]   next_sh;
	psi_byte_t    ptr;
	psi_byte_t    next_ptr;
	psi_byte_t    wr_data;
	psi_byte_t    next_wr_data;
	logic         ptr_tog;
	logic         next_ptr_tog;
	logic         wr_tog;
	logic         next_wr_tog;
	psi_byte_t    rx_byte;
	psi_byte_t    tx;
	psi_byte_t    next_tx;
	logic         sda_oe;
	logic         next_sda_oe;
	logic [2:0]   tx_idx;

	// System domain
	logic         scl_m, scl_s, sda_m, sda_s, sda_d;
	logic [1:0]   tog_m, tog_s, tog_d;
	logic         start_det, stop_det;
	logic         in_frame, next_in_frame;
	logic         link_rstn, next_link_rstn;
	logic         ptr_ev, wr_ev, soft_rst, start_cv;
	psi_byte_t    ptr_sys, next_ptr_sys;
	psi_byte_t    ctrl, next_ctrl;
	psi_byte_t    res_msb, next_res_msb;
	psi_byte_t    res_lsb, next_res_lsb;
	psi_byte_t    res_xlsb, next_res_xlsb;
	psi_byte_t    rd_byte, next_rd_byte;

	assign rx_byte = {sh, sda_i};

	// Bit engine samples data on the rising bus clock edge
	always_comb begin
		next_st      = st;
		next_sh      = sh;
		next_ptr     = ptr;
		next_ptr_tog = ptr_tog;
		next_wr_data = wr_data;
		next_wr_tog  = wr_tog;
		next_bit_cnt = 4'd0;
		if (bit_cnt != 4'd8) begin
			next_sh      = {sh[5:0], sda_i};
			next_bit_cnt = bit_cnt + 4'd1;
		end
		if (bit_cnt == 4'd7) begin
			case (st)
				ST_ADDR: begin
					if (rx_byte[7:1] != `PSI_SLAVE_ADDR)
						next_st = ST_WAIT;
				end
				ST_REG: begin
					next_ptr     = rx_byte;
					next_ptr_tog = ~ptr_tog;
				end
				ST_WDATA: begin
					next_wr_data = rx_byte;
					next_wr_tog  = ~wr_tog;
				end
				default: ;
			endcase
		end
		if (bit_cnt == 4'd8) begin
			case (st)
				ST_ADDR:  next_st = sh[0] ? ST_RDATA : ST_REG;
				ST_REG:   next_st = ST_WDATA;
				ST_WDATA: next_st = ST_WDATA;
				ST_RDATA: next_st = sda_i ? ST_WAIT : ST_RDATA;
				default:  next_st = ST_WAIT;
			endcase
		end
		if (st == ST_RDATA && bit_cnt == 4'd0) begin
			next_ptr     = ptr + 8'h01;
			next_ptr_tog = ~ptr_tog;
		end
	end

	// Link logic is held in reset outside frames
	always_ff @(posedge scl_i or negedge link_rstn) begin
		if (!link_rstn) begin
			st      <= ST_ADDR;
			bit_cnt <= 4'd0;
			sh      <= 7'h00;
		end else begin
			st      <= next_st;
			bit_cnt <= next_bit_cnt;
			sh      <= next_sh;
		end
	end

	// Pointer, write word and toggles outlive frame resets: a repeated start keeps the pointer
	always_ff @(posedge scl_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr     <= 8'h00;
			ptr_tog <= 1'b0;
			wr_data <= 8'h00;
			wr_tog  <= 1'b0;
		end else begin
			ptr     <= next_ptr;
			ptr_tog <= next_ptr_tog;
			wr_data <= next_wr_data;
			wr_tog  <= next_wr_tog;
		end
	end

	assign tx_idx = 3'd7 - bit_cnt[2:0];

	// Data is driven on the falling clock edge only
	always_comb begin
		next_tx     = tx;
		next_sda_oe = 1'b0;
		if (bit_cnt == 4'd8 && (st == ST_ADDR || st == ST_REG || st == ST_WDATA))
			next_sda_oe = 1'b1;
		else if (st == ST_RDATA && bit_cnt == 4'd0) begin
			next_tx     = rd_byte;
			next_sda_oe = ~rd_byte[7];
		end else if (st == ST_RDATA && bit_cnt != 4'd8)
			next_sda_oe = ~tx[tx_idx];
	end

	always_ff @(negedge scl_i or negedge link_rstn) begin
		if (!link_rstn) begin
			tx     <= 8'h00;
			sda_oe <= 1'b0;
		end else begin
			tx     <= next_tx;
			sda_oe <= next_sda_oe;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_oe;
	assign scl_o    = 1'b0;
	assign scl_oe_o = 1'b0;

	// Pin and toggle synchronisers
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			tog_m <= 2'b00;
			tog_s <= 2'b00;
			tog_d <= 2'b00;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
			tog_m <= {wr_tog, ptr_tog};
			tog_s <= tog_m;
			tog_d <= tog_s;
		end
	end

	assign start_det = scl_s && sda_d && !sda_s;
	assign stop_det  = scl_s && !sda_d && sda_s;
	assign ptr_ev    = tog_s[0] ^ tog_d[0];
	assign wr_ev     = tog_s[1] ^ tog_d[1];
	assign soft_rst  = wr_ev && ptr == `PSI_REG_SRST && wr_data == `PSI_SRST_KEY;
	assign start_cv  = wr_ev && ptr == `PSI_REG_CTRL && wr_data[`PSI_SCO_BIT] && !cif.busy;

	assign cif.start = start_cv;
	assign cif.abort = soft_rst;
	assign cif.meas  = wr_data[4:0];
	assign cif.oss   = wr_data[7:6];

	function automatic psi_byte_t reg_read(input psi_byte_t a);
		logic [4:0] i;
		i = 5'(a - `PSI_REG_CALIB);
		reg_read = 8'h00;
		if (a >= `PSI_REG_CALIB && a <= `PSI_REG_CALIB_END)
			reg_read = CALIB[8*i +: 8];
		else begin
			case (a)
				`PSI_REG_ID:   reg_read = CHIP_ID;
				`PSI_REG_CTRL: reg_read = {ctrl[7:6], cif.busy, ctrl[4:0]};
				`PSI_REG_MSB:  reg_read = res_msb;
				`PSI_REG_LSB:  reg_read = res_lsb;
				`PSI_REG_XLSB: reg_read = res_xlsb;
				default:       reg_read = 8'h00;
			endcase
		end
	endfunction

	always_comb begin
		next_in_frame  = start_det ? 1'b1 : (stop_det ? 1'b0 : in_frame);
		next_link_rstn = next_in_frame && !start_det;
		next_ptr_sys   = ptr_ev ? ptr : ptr_sys;
		next_ctrl      = ctrl;
		next_res_msb   = res_msb;
		next_res_lsb   = res_lsb;
		next_res_xlsb  = res_xlsb;
		next_rd_byte   = reg_read(ptr_sys);
		if (wr_ev && ptr == `PSI_REG_CTRL && !cif.busy)
			next_ctrl = wr_data;
		if (cif.done) begin
			next_res_msb  = cif.result[23:16];
			next_res_lsb  = cif.result[15:8];
			next_res_xlsb = cif.result[7:0];
		end
		if (soft_rst) begin
			next_ctrl     = `PSI_CTRL_RST;
			next_res_msb  = `PSI_MSB_RST;
			next_res_lsb  = `PSI_LSB_RST;
			next_res_xlsb = `PSI_XLSB_RST;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			in_frame  <= 1'b0;
			link_rstn <= 1'b0;
			ptr_sys   <= 8'h00;
			ctrl      <= `PSI_CTRL_RST;
			res_msb   <= `PSI_MSB_RST;
			res_lsb   <= `PSI_LSB_RST;
			res_xlsb  <= `PSI_XLSB_RST;
			rd_byte   <= 8'h00;
		end else begin
			in_frame  <= next_in_frame;
			link_rstn <= next_link_rstn;
			ptr_sys   <= next_ptr_sys;
			ctrl      <= next_ctrl;
			res_msb   <= next_res_msb;
			res_lsb   <= next_res_lsb;
			res_xlsb  <= next_res_xlsb;
			rd_byte   <= next_rd_byte;
		end
	end

	psi_conv #(
		.CNT_W      (CNT_W),
		.T_TEMP_CYC (T_TEMP_CYC),
		.T_P0_CYC   (T_P0_CYC),
		.T_P1_CYC   (T_P1_CYC),
		.T_P2_CYC   (T_P2_CYC),
		.T_P3_CYC   (T_P3_CYC)
	) u_conv (
		.clk_sys_i         (clk_sys_i),
		.rstn_i            (rstn_i),
		.cif               (cif.conv),
		.raw_temperature_i (raw_temperature_i),
		.raw_pressure_i    (raw_pressure_i)
	);

	// Checks on the system clock
	frame_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stop_det |=> !link_rstn)
		else $error("stop did not reset the link logic");
	soft_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		soft_rst |=> ctrl == 8'h00 && res_msb == 8'h80 && !cif.busy)
		else $error("soft reset key did not restore reset values");
	meas_select_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		start_cv |=> cif.busy && ctrl[4:0] == $past(wr_data[4:0]))
		else $error("measurement select not taken on start");
	oss_field_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		start_cv |=> ctrl[7:6] == $past(wr_data[7:6]))
		else $error("oversampling field not stored");
	sco_done_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cif.done |=> !cif.busy && res_msb == $past(cif.result[23:16]))
		else $error("busy cleared without fresh result");
	chip_id_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		ptr_sys == 8'hd0 |=> rd_byte == CHIP_ID)
		else $error("identification byte wrong");
	any_order_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		ptr_sys == 8'hf7 |=> rd_byte == $past(res_lsb))
		else $error("low result byte not returned");

	// Checks on the bus clock
	addr_ack_a: assert property (@(posedge scl_i) disable iff (!link_rstn)
		(st == ST_ADDR && bit_cnt == 4'd8) |-> sda_oe)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (@(posedge scl_i) disable iff (!link_rstn)
		(st == ST_ADDR && bit_cnt == 4'd7 && sh != 7'h77) |=> st == ST_WAIT)
		else $error("foreign address not ignored");
	ptr_step_a: assert property (@(posedge scl_i) disable iff (!link_rstn)
		(st == ST_RDATA && bit_cnt == 4'd0) |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance");
	master_ack_a: assert property (@(posedge scl_i) disable iff (!link_rstn)
		(st == ST_RDATA && bit_cnt == 4'd8) |-> !sda_oe)
		else $error("data line held during master acknowledge");

	conv_done_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) cif.done);
	soft_rst_c:  cover property (@(posedge clk_sys_i) disable iff (!rstn_i) soft_rst);
	wr_byte_c:   cover property (@(posedge scl_i) disable iff (!link_rstn)
		st == ST_WDATA && bit_cnt == 4'd8);
	rd_nack_c:   cover property (@(posedge scl_i) disable iff (!link_rstn)
		st == ST_RDATA && bit_cnt == 4'd8 && sda_i);
endmodule // psi_top
`default_nettype wire

// *** pkg/psi_params.svh ***
// Register offsets, reset values, field positions and timing counts of the sensor port
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH

`define PSI_CLK_MHZ       50
`define PSI_SLAVE_ADDR    7'h77
`define PSI_REG_CALIB     8'haa
`define PSI_REG_CALIB_END 8'hbf
`define PSI_REG_ID        8'hd0
`define PSI_REG_SRST      8'he0
`define PSI_REG_CTRL      8'hf4
`define PSI_REG_MSB       8'hf6
`define PSI_REG_LSB       8'hf7
`define PSI_REG_XLSB      8'hf8
`define PSI_SRST_KEY      8'hb6
`define PSI_CTRL_RST      8'h00
`define PSI_MSB_RST       8'h80
`define PSI_LSB_RST       8'h00
`define PSI_XLSB_RST      8'h00
`define PSI_SCO_BIT       5
`define PSI_MEAS_PRES     5'h14
`define PSI_T_TEMP_US     4500
`define PSI_T_P0_US       4500
`define PSI_T_P1_US       7500
`define PSI_T_P2_US       13500
`define PSI_T_P3_US       25500
`define PSI_US2CYC(us)    ((us) * `PSI_CLK_MHZ)

`endif

// *** pkg/psi_pkg.sv ***
// Types shared by the sensor port modules
package psi_pkg;
	typedef enum logic [2:0] {
		ST_ADDR  = 3'b000,
		ST_REG   = 3'b001,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b010,
		ST_WAIT  = 3'b110
	} psi_link_st_t;
	typedef logic [7:0] psi_byte_t;
endpackage

// *** pkg/psi_conv_if.sv ***
// Signals between the register file and the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
interface psi_conv_if;
	logic        start;
	logic        abort;
	logic [4:0]  meas;
	logic [1:0]  oss;
	logic        busy;
	logic        done;
	logic [23:0] result;
	modport ctrl (output start, abort, meas, oss, input busy, done, result);
	modport conv (input start, abort, meas, oss, output busy, done, result);
endinterface
`default_nettype wire

// *** verilog/psi_conv.sv ***
// Conversion sequencer: times one measurement and presents its raw result
`timescale 1ns/100ps
`default_nettype none
`include "psi_params.svh"
module psi_conv import psi_pkg::*; #(
	parameter int unsigned CNT_W      = 21,
	parameter int unsigned T_TEMP_CYC = `PSI_US2CYC(`PSI_T_TEMP_US),
	parameter int unsigned T_P0_CYC   = `PSI_US2CYC(`PSI_T_P0_US),
	parameter int unsigned T_P1_CYC   = `PSI_US2CYC(`PSI_T_P1_US),
	parameter int unsigned T_P2_CYC   = `PSI_US2CYC(`PSI_T_P2_US),
	parameter int unsigned T_P3_CYC   = `PSI_US2CYC(`PSI_T_P3_US)
) (
	input  wire logic        clk_sys_i,          // System clock
	input  wire logic        rstn_i,             // Async reset, active low
	psi_conv_if.conv         cif,                // Start and result handshake
	input  wire logic [15:0] raw_temperature_i,  // Front end temperature word
	input  wire logic [18:0] raw_pressure_i      // Front end pressure word
);
	logic             busy;
	logic             is_pres;
	logic [CNT_W-1:0] cnt;
	logic             next_busy;
	logic             next_is_pres;
	logic [CNT_W-1:0] next_cnt;

	always_comb begin
		next_busy    = busy;
		next_is_pres = is_pres;
		next_cnt     = cnt;
		if (cif.abort) begin
			next_busy = 1'b0;
			next_cnt  = '0;
		end else if (cif.start) begin
			next_busy    = 1'b1;
			next_is_pres = (cif.meas == `PSI_MEAS_PRES);
			if (cif.meas != `PSI_MEAS_PRES)
				next_cnt = CNT_W'(T_TEMP_CYC);
			else begin
				case (cif.oss)
					2'b00:   next_cnt = CNT_W'(T_P0_CYC);
					2'b01:   next_cnt = CNT_W'(T_P1_CYC);
					2'b10:   next_cnt = CNT_W'(T_P2_CYC);
					default: next_cnt = CNT_W'(T_P3_CYC);
				endcase
			end
		end else if (busy) begin
			next_cnt = cnt - CNT_W'(1);
			if (cnt == CNT_W'(1))
				next_busy = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy    <= 1'b0;
			is_pres <= 1'b0;
			cnt     <= '0;
		end else begin
			busy    <= next_busy;
			is_pres <= next_is_pres;
			cnt     <= next_cnt;
		end
	end

	assign cif.busy   = busy;
	assign cif.done   = busy && (cnt == CNT_W'(1)) && !cif.abort;
	assign cif.result = is_pres ? {raw_pressure_i, 5'h00} : {raw_temperature_i, 8'h00};
endmodule // psi_conv
`default_nettype wire

// *** sim/psi_master.sv ***
// Behavioural two-wire bus master that drives the sensor port
`timescale 1ns/100ps
`default_nettype none
module psi_master #(
	parameter int unsigned HALF_NS = 32,  // Half period of the bus clock
	parameter int unsigned HOLD_NS = 96   // Clock high time around start and stop
) (
	input  wire logic sda_i,      // Resolved data line level
	output logic      scl_low_o,  // Master pulls the clock line low
	output logic      sda_low_o   // Master pulls the data line low
);
	localparam int unsigned SETUP_NS = 8;

	// Clock stands released between frames
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	task automatic start_cond;
		sda_low_o = 1'b1;
		#HOLD_NS scl_low_o = 1'b1;
	endtask

	task automatic restart_cond;
		#SETUP_NS sda_low_o = 1'b0;
		#(HALF_NS - SETUP_NS) scl_low_o = 1'b0;
		#HOLD_NS start_cond();
	endtask

	task automatic stop_cond;
		#SETUP_NS sda_low_o = 1'b1;
		#(HALF_NS - SETUP_NS) scl_low_o = 1'b0;
		#HOLD_NS sda_low_o = 1'b0;
		#HOLD_NS;
	endtask

	// Data moves a little after the clock falls and stands while it is high
	task automatic bit_out(input logic b);
		#SETUP_NS sda_low_o = ~b;
		#(HALF_NS - SETUP_NS) scl_low_o = 1'b0;
		#HALF_NS scl_low_o = 1'b1;
	endtask

	task automatic bit_in(output logic b);
		#SETUP_NS sda_low_o = 1'b0;
		#(HALF_NS - SETUP_NS) scl_low_o = 1'b0;
		b = sda_i;
		#HALF_NS scl_low_o = 1'b1;
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(b);
		ack = ~b;
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask

	task automatic write_frame(input logic [7:0] adr, reg_a, dat, output logic [2:0] acks);
		start_cond();
		send_byte(adr, acks[2]);
		send_byte(reg_a, acks[1]);
		send_byte(dat, acks[0]);
		stop_cond();
	endtask

	// Last byte is followed by a not-acknowledge
	task automatic read_frame(input logic [7:0] reg_a, input int n, output logic [2:0] acks,
		output logic [23:0] d);
		logic [7:0] b;
		start_cond();
		send_byte(8'hee, acks[2]);
		send_byte(reg_a, acks[1]);
		restart_cond();
		send_byte(8'hef, acks[0]);
		d = 24'h0;
		for (int i = 0; i < n; i++) begin
			recv_byte(i == n - 1, b);
			d = {d[15:0], b};
		end
		stop_cond();
	endtask
endmodule // psi_master
`default_nettype wire

// *** sim/test_psi_top.sv ***
// Self-checking testbench of the sensor port over the two-wire bus
`timescale 1ns/100ps
`default_nettype none
`include "psi_params.svh"
module test_psi_top import psi_pkg::*;;
	localparam logic [175:0] CAL = 176'h0123_4567_89ab_cdef_fedc_ba98_7654_3210_0f1e_2d3c_4b5a;
	localparam logic [7:0]   CID = 8'h3c; // Arbitrary identification value
	localparam int           T_T = 400;
	localparam int           T_P [4] = '{400, 600, 800, 1000};

	logic        clk_sys_i;
	logic        rstn_i;
	logic [15:0] raw_temperature;
	logic [18:0] raw_pressure;
	logic        m_scl_low;
	logic        m_sda_low;
	wire  logic  sda_oe;
	wire  logic  scl_oe;
	wire  logic  sda_dv;
	wire  logic  scl_dv;
	wire  logic  scl_w;
	wire  logic  sda_w;
	int          num_errors = 0;
	int          total_checks = 0;

	// Open-drain lines with pull-ups
	assign scl_w = ~((scl_oe & ~scl_dv) | m_scl_low);
	assign sda_w = ~((sda_oe & ~sda_dv) | m_sda_low);

	psi_top #(
		.CALIB     (CAL),
		.CHIP_ID   (CID),
		.T_TEMP_CYC(T_T),
		.T_P0_CYC  (T_P[0]),
		.T_P1_CYC  (T_P[1]),
		.T_P2_CYC  (T_P[2]),
		.T_P3_CYC  (T_P[3])
	) psi_top_inst (
		.clk_sys_i        (clk_sys_i),
		.rstn_i           (rstn_i),
		.scl_i            (scl_w),
		.sda_i            (sda_w),
		.sda_o            (sda_dv),
		.sda_oe_o         (sda_oe),
		.scl_o            (scl_dv),
		.scl_oe_o         (scl_oe),
		.raw_temperature_i(raw_temperature),
		.raw_pressure_i   (raw_pressure)
	);

	psi_master psi_master_inst (
		.sda_i    (sda_w),
		.scl_low_o(m_scl_low),
		.sda_low_o(m_sda_low)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask

	// Host power-up wait shortened to a few cycles
	task automatic do_reset;
		rstn_i = 1'b0;
		cyc(5);
		rstn_i = 1'b1;
		cyc(5);
	endtask

	task automatic wr(input psi_byte_t adr, dat);
		logic [2:0] acks;
		cyc(1);
		psi_master_inst.write_frame(8'hee, adr, dat, acks);
		check({21'h0, acks}, 24'h7);
	endtask

	task automatic rd(input psi_byte_t adr, input int n, input logic [23:0] exp);
		logic [2:0]  acks;
		logic [23:0] d;
		cyc(1);
		psi_master_inst.read_frame(adr, n, acks, d);
		check({21'h0, acks}, 24'h7);
		check(d, exp);
	endtask

	// Start, overwrite while busy, then sample busy about 130 cycles before and 360 cycles after the end
	task automatic conv(input psi_byte_t code, input int t_cyc, input logic [23:0] res);
		wr(`PSI_REG_CTRL, code);
		wr(`PSI_REG_CTRL, 8'h00);
		cyc(t_cyc - 350);
		rd(`PSI_REG_CTRL, 1, {16'h0, code});
		cyc(350);
		rd(`PSI_REG_CTRL, 1, {16'h0, code & 8'hdf});
		rd(`PSI_REG_MSB, 3, res);
	endtask

	initial begin
		logic [2:0] acks;
		rstn_i = 1'b0;
		raw_temperature = 16'hbeef;
		raw_pressure = 19'h5a5a5;
		do_reset();
		rd(`PSI_REG_CTRL, 1, 24'h0);
		rd(`PSI_REG_MSB, 3, 24'h800000);
		rd(`PSI_REG_ID, 1, {16'h0, CID});
		rd(`PSI_REG_SRST, 1, 24'h0);
		rd(8'h10, 1, 24'h0);
		rd(`PSI_REG_CALIB, 3, {CAL[7:0], CAL[15:8], CAL[23:16]});
		rd(`PSI_REG_CALIB_END, 1, {16'h0, CAL[175:168]});
		// Foreign slave address is neither acknowledged nor acted on
		cyc(1);
		psi_master_inst.write_frame(8'hd0, `PSI_REG_CTRL, 8'h2e, acks);
		check({21'h0, acks}, 24'h0);
		rd(`PSI_REG_CTRL, 1, 24'h0);
		conv(8'h2e, T_T, {raw_temperature, 8'h00});
		rd(`PSI_REG_XLSB, 1, 24'h0);
		rd(`PSI_REG_LSB, 1, {16'h0, raw_temperature[7:0]});
		rd(`PSI_REG_MSB, 1, {16'h0, raw_temperature[15:8]});
		for (int k = 0; k < 4; k++) begin
			cyc(1);
			raw_pressure = {k[1:0], 17'h1a5c3};
			conv({k[1:0], 6'h34}, T_P[k], {raw_pressure, 5'h00});
		end
		wr(`PSI_REG_SRST, 8'h5a);
		rd(`PSI_REG_MSB, 3, {raw_pressure, 5'h00});
		wr(`PSI_REG_SRST, `PSI_SRST_KEY);
		rd(`PSI_REG_CTRL, 1, 24'h0);
		rd(`PSI_REG_MSB, 3, 24'h800000);
		// Power-on reset in mid-conversion
		wr(`PSI_REG_CTRL, 8'h2e);
		do_reset();
		rd(`PSI_REG_CTRL, 1, 24'h0);
		rd(`PSI_REG_MSB, 3, 24'h800000);
		final_report();
	end

	// Whole run needs well under half of this span
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		num_errors++;
		final_report();
	end
endmodule // test_psi_top
`default_nettype wire
